// [logic/sic_pkg.sv]
// Purpose: shared constants and types of the six-source interrupt controller
// Assumes: one 125 MHz core clock, data-memory style register access
// Notes: source index 0..5 is also the priority order, 0 highest
package sic_pkg;

  // number of interrupt sources and data widths
  localparam int SIC_NSRC = 6;
  localparam int SIC_DW = 8;
  localparam int SIC_AW = 8;
  localparam int SIC_SW = 3;

  // source indices
  localparam int SIC_SRC_EXT0 = 0;
  localparam int SIC_SRC_EXT1 = 1;
  localparam int SIC_SRC_TMR0 = 2;
  localparam int SIC_SRC_TMR1 = 3;
  localparam int SIC_SRC_TBASE = 4;
  localparam int SIC_SRC_RTC = 5;

  // register addresses in data memory
  localparam logic [SIC_AW-1:0] SIC_ADDR_CTRL_LOW = 8'h0B;
  localparam logic [SIC_AW-1:0] SIC_ADDR_CTRL_HIGH = 8'h1E;

  // interrupt_control_low field positions
  localparam int SIC_LOW_MASTER = 0;
  localparam int SIC_LOW_EN_BASE = 1;
  localparam int SIC_LOW_FLAG_BASE = 4;
  localparam int SIC_LOW_TEST = 7;
  // interrupt_control_high field positions
  localparam int SIC_HIGH_EN_BASE = 0;
  localparam int SIC_HIGH_FLAG_BASE = 4;
  // sources held in the low register, the rest live in the high one
  localparam int SIC_LOW_SRCS = 3;

  // values after reset: everything disabled, no request pending
  localparam logic [SIC_NSRC-1:0] SIC_RST_FLAGS = 6'h00;
  localparam logic [SIC_NSRC-1:0] SIC_RST_ENABLES = 6'h00;
  localparam logic SIC_RST_MASTER = 1'b0;
  localparam logic [SIC_DW-1:0] SIC_RST_RDATA = 8'h00;

  // vectors: base plus one step per priority level
  localparam logic [SIC_DW-1:0] SIC_VECTOR_BASE = 8'h04;
  localparam logic [SIC_DW-1:0] SIC_VECTOR_STEP = 8'h04;

  // acknowledge handed to the core: call strobe, vector, granted source
  typedef struct packed {
    logic call;
    logic [SIC_DW-1:0] vector;
    logic [SIC_SW-1:0] source;
  } sic_ack_s;

  localparam sic_ack_s SIC_RST_ACK = '{call: 1'b0, vector: 8'h00, source: 3'h0};

  // acknowledge sequencer
  typedef enum logic [1:0] {
    SIC_ST_IDLE = 2'b01,
    SIC_ST_CALL = 2'b10
  } sic_state_e;

endpackage : sic_pkg

// [logic/sic_pin_edge.sv]
// Purpose: synchronise one external interrupt pin and detect its active edge
// Assumes: pin is asynchronous to core_clk
// Notes: the first stage feeds only the second stage
`timescale 1ns/10ps
module sic_pin_edge
  import sic_pkg::*;
#(
  parameter bit RISING = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic edge_seen
);

  logic sync1;
  logic sync2;
  logic prev;

  // reset to the idle level so release from reset with the pin at its idle level never looks like an edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= ~RISING;
      sync2 <= ~RISING;
      prev <= ~RISING;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // build-time choice of the triggering edge
  always_comb begin
    if (RISING) begin
      edge_seen = sync2 & ~prev;
    end else begin
      edge_seen = ~sync2 & prev;
    end
  end

endmodule : sic_pin_edge

// [logic/sic_top.sv]
// Purpose: six-source prioritised interrupt controller seen by the core
// Assumes: core strobes, data port and timer events share core_clk
// Notes: acknowledge is judged only on cycle_phase_two pulses
// How it works
// - hold other requests until master enable returns
// - return-with-enable sets master enable; plain return not
// - requests seen between phase pulses serviced next pulse
// - simultaneous requests granted external 0 first, RTC last
// - vectors 04H to 18H in four-byte steps
// - master enable cleared blocks every acknowledge
// - low control register at 0BH, master plus three
// - high control register at 1EH, three sources
// - disabled requests still flagged, never serviced
// - flags stick until serviced or software clears
// - low register bit map, bit 7 test only
// - high register bit map, bits 3, 7 zero
// - acknowledge pushes, branches, clears flag and master
// - external flags set by build-selected pin edge
`timescale 1ns/10ps
module sic_top
  import sic_pkg::*;
#(
  parameter bit EXT0_RISING = 1'b0,
  parameter bit EXT1_RISING = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ext_irq_pin_zero,
  input wire logic ext_irq_pin_one,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timebase_tick,
  input wire logic rtc_tick,
  input wire logic cycle_phase_two,
  input wire logic stack_full,
  input wire logic return_with_enable_instr,
  input wire logic plain_return_instr,
  input wire logic [SIC_AW-1:0] mem_addr,
  input wire logic mem_wr,
  input wire logic [SIC_DW-1:0] mem_wdata,
  output logic [SIC_DW-1:0] mem_rdata,
  output sic_ack_s irq_ack
);

  logic [SIC_NSRC-1:0] request_flag;
  logic [SIC_NSRC-1:0] irq_enable;
  logic master_irq_enable;
  logic [SIC_NSRC-1:0] src_event;
  logic [SIC_NSRC-1:0] pending;
  logic [SIC_NSRC-1:0] ack_clear;
  logic [SIC_NSRC-1:0] wr_hit;
  logic [SIC_NSRC-1:0] wr_flag;
  logic [SIC_NSRC-1:0] wr_en;
  logic wr_low;
  logic wr_high;
  logic grant_now;
  logic [SIC_SW-1:0] grant_src;
  logic ext0_edge;
  logic ext1_edge;
  sic_state_e state;
  sic_state_e next_state;

  // external pins: two-stage sync then edge pick
  sic_pin_edge #(.RISING(EXT0_RISING)) u_ext0 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(ext_irq_pin_zero),
    .edge_seen(ext0_edge)
  );
  sic_pin_edge #(.RISING(EXT1_RISING)) u_ext1 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin(ext_irq_pin_one),
    .edge_seen(ext1_edge)
  );

  assign src_event = {rtc_tick, timebase_tick, timer1_overflow, timer0_overflow,
                      ext1_edge, ext0_edge};

  // register write decode
  assign wr_low = mem_wr && (mem_addr == SIC_ADDR_CTRL_LOW);
  assign wr_high = mem_wr && (mem_addr == SIC_ADDR_CTRL_HIGH);

  // per-source field mapping into the two control registers
  genvar gi;
  generate
    for (gi = 0; gi < SIC_NSRC; gi++) begin : g_src
      if (gi < SIC_LOW_SRCS) begin : g_low
        assign wr_hit[gi] = wr_low;
        assign wr_flag[gi] = mem_wdata[SIC_LOW_FLAG_BASE + gi];
        assign wr_en[gi] = mem_wdata[SIC_LOW_EN_BASE + gi];
      end else begin : g_high
        assign wr_hit[gi] = wr_high;
        assign wr_flag[gi] = mem_wdata[SIC_HIGH_FLAG_BASE + gi - SIC_LOW_SRCS];
        assign wr_en[gi] = mem_wdata[SIC_HIGH_EN_BASE + gi - SIC_LOW_SRCS];
      end

      // sticky flag; a new event beats both software and acknowledge clears
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          request_flag[gi] <= SIC_RST_FLAGS[gi];
        end else if (src_event[gi]) begin
          request_flag[gi] <= 1'b1;
        end else if (wr_hit[gi]) begin
          request_flag[gi] <= wr_flag[gi];
        end else if (ack_clear[gi]) begin
          request_flag[gi] <= 1'b0;
        end
      end

      // per-source enables are plain software bits
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          irq_enable[gi] <= SIC_RST_ENABLES[gi];
        end else if (wr_hit[gi]) begin
          irq_enable[gi] <= wr_en[gi];
        end
      end
    end
  endgenerate

  // a flag only counts when both its enable and the master enable are set
  assign pending = request_flag & irq_enable & {SIC_NSRC{master_irq_enable}};

  // fixed priority: lowest index wins
  always_comb begin
    grant_src = '0;
    for (int i = SIC_NSRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        grant_src = SIC_SW'(i);
      end
    end
  end

  // judged only on a phase pulse, never while the stack has no room
  assign grant_now = (state == SIC_ST_IDLE) && cycle_phase_two && !stack_full
                     && (|pending);
  assign ack_clear = grant_now ? (SIC_NSRC'(1) << grant_src) : '0;

  // master enable: return-with-enable sets it and wins over everything
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_irq_enable <= SIC_RST_MASTER;
    end else if (return_with_enable_instr) begin
      master_irq_enable <= 1'b1;
    end else if (wr_low) begin
      master_irq_enable <= mem_wdata[SIC_LOW_MASTER];
    end else if (grant_now) begin
      master_irq_enable <= 1'b0;
    end
  end

  // acknowledge sequencer: one call cycle per grant
  always_comb begin
    case (state)
      SIC_ST_IDLE: next_state = grant_now ? SIC_ST_CALL : SIC_ST_IDLE;
      SIC_ST_CALL: next_state = SIC_ST_IDLE;
      default: next_state = SIC_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SIC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // vector and source registered together with the call strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack <= SIC_RST_ACK;
    end else begin
      irq_ack.call <= (next_state == SIC_ST_CALL);
      if (grant_now) begin
        irq_ack.vector <= SIC_VECTOR_BASE
                          + SIC_DW'(SIC_VECTOR_STEP * SIC_DW'(grant_src));
        irq_ack.source <= grant_src;
      end
    end
  end

  // read port, one cycle behind the address; test bit and gaps read zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata <= SIC_RST_RDATA;
    end else if (mem_addr == SIC_ADDR_CTRL_LOW) begin
      mem_rdata <= {1'b0, request_flag[2:0], irq_enable[2:0], master_irq_enable};
    end else if (mem_addr == SIC_ADDR_CTRL_HIGH) begin
      mem_rdata <= {1'b0, request_flag[5:3], 1'b0, irq_enable[5:3]};
    end else begin
      mem_rdata <= SIC_RST_RDATA;
    end
  end

  // ---- checks ----
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_phase_grant;
    (state == SIC_ST_IDLE) && cycle_phase_two && !stack_full && (|pending);
  endsequence

  sequence s_call_pulse;
    irq_ack.call ##1 !irq_ack.call;
  endsequence

  chk_phase_service: assert property (s_phase_grant |=> s_call_pulse)
    else $error("enabled request not acknowledged at phase pulse");

  chk_master_blocks: assert property (!master_irq_enable |=> !irq_ack.call)
    else $error("call issued with master enable cleared");

  chk_stack_full_hold: assert property (stack_full |=> !irq_ack.call)
    else $error("call issued while stack full");

  chk_call_clears_master: assert property (
    irq_ack.call && !$past(return_with_enable_instr) && !$past(wr_low)
    |-> !master_irq_enable ##1 !irq_ack.call)
    else $error("master enable still set after acknowledge");

  chk_return_with_enable_instr_sets_master: assert property (return_with_enable_instr |=> master_irq_enable)
    else $error("return-with-enable did not set master enable");

  chk_plain_ret_keeps: assert property (
    plain_return_instr && !return_with_enable_instr && !wr_low && !grant_now
    |=> $stable(master_irq_enable))
    else $error("plain return changed master enable");

  chk_vector_map: assert property (
    irq_ack.call |-> irq_ack.vector == SIC_DW'(8'h04 + 8'h04 * irq_ack.source))
    else $error("vector does not match granted source");

  // only the sampled vectors are taken from the grant cycle; the index is the source shown now
  chk_priority_order: assert property (
    irq_ack.call |-> (($past(pending) & ((SIC_NSRC'(1) << irq_ack.source) - 1'b1)) == '0)
    && (|($past(pending) & (SIC_NSRC'(1) << irq_ack.source))))
    else $error("lower priority source granted first");

  chk_disabled_unserved: assert property (
    irq_ack.call |-> |($past(irq_enable) & (SIC_NSRC'(1) << irq_ack.source)))
    else $error("disabled source acknowledged");

  chk_event_wins: assert property (src_event[SIC_SRC_EXT0] |=> request_flag[SIC_SRC_EXT0])
    else $error("external 0 event lost");

  chk_flag_sticky: assert property (
    request_flag[SIC_SRC_RTC] && !wr_high && !ack_clear[SIC_SRC_RTC]
    |=> request_flag[SIC_SRC_RTC])
    else $error("rtc flag dropped without clear");

endmodule : sic_top

// [sim/sic_core_model.sv]
// Purpose: core-side model giving phase-two pulses and the stack state
// Assumes: one phase-two pulse every four core cycles
// Notes: stack level is commanded by the bench
`timescale 1ns/10ps
module sic_core_model
  import sic_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hold_stack,
  output logic cycle_phase_two,
  output logic stack_full
);
  logic [1:0] phase_cnt;

  // four-cycle machine cycle, phase two in its last quarter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt <= 2'h0;
    end else begin
      phase_cnt <= phase_cnt + 2'h1;
    end
  end
  assign cycle_phase_two = (phase_cnt == 2'h3);

  // no calls inside a service routine, so the stack fills only when told
  assign stack_full = hold_stack;
endmodule : sic_core_model

// [sim/six_source_interrupt_controller_bench.sv]
// Purpose: self-checking bench of the interrupt controller
// Assumes: falling pin edges trigger, core model paces phase two
// Notes: every wait is bounded
`timescale 1ns/10ps
module six_source_interrupt_controller_bench;
  import sic_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] pins = 2'b11;
  logic [5:0] ev = 6'h00;
  logic hold_stack = 1'b0;
  logic cycle_phase_two;
  logic stack_full;
  logic [7:0] mem_addr = 8'h00;
  logic mem_wr = 1'b0;
  logic [7:0] mem_wdata = 8'h00;
  logic [7:0] mem_rdata;
  sic_ack_s irq_ack;
  int n_errors = 0;
  int check_count = 0;
  int n_calls = 0;
  int c0;
  logic [31:0] rnd = 32'h00010644;
  logic [7:0] v;

  // clock and acknowledge counter
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (irq_ack.call === 1'b1) n_calls++;

  sic_core_model i_sic_core_model (.core_clk(core_clk), .rst_n(rst_n),
    .hold_stack(hold_stack), .cycle_phase_two(cycle_phase_two), .stack_full(stack_full));
  sic_top i_sic_top (.core_clk(core_clk), .rst_n(rst_n), .ext_irq_pin_zero(pins[0]),
    .ext_irq_pin_one(pins[1]), .timer0_overflow(ev[0]), .timer1_overflow(ev[1]),
    .timebase_tick(ev[2]), .rtc_tick(ev[3]), .cycle_phase_two(cycle_phase_two),
    .stack_full(stack_full), .return_with_enable_instr(ev[4]), .plain_return_instr(ev[5]),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .irq_ack(irq_ack));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // vector expected for a priority level
  function automatic logic [7:0] vec_of(input int i);
    return SIC_VECTOR_BASE + SIC_VECTOR_STEP * 8'(i);
  endfunction : vec_of

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge core_clk);
    mem_wr <= 1'b0;
  endtask : wr

  // read data lands one cycle after the address
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    mem_addr <= a;
    @(posedge core_clk);
    #1 v = mem_rdata;
  endtask : rd

  task automatic pulse(input logic [5:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 6'h00;
  endtask : pulse

  task automatic wait_call();
    int start;
    start = n_calls;
    for (int i = 0; i < 40 && n_calls == start; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (n_calls == start) begin
      chk(8'(n_calls - start), 8'h01);
      finish_test();
    end
  endtask : wait_call

  initial begin
    cyc(5);
    rst_n <= 1'b1;
    // register map, reserved bits, unmapped address
    rd(SIC_ADDR_CTRL_LOW); chk(v, 8'h00);
    rd(SIC_ADDR_CTRL_HIGH); chk(v, 8'h00);
    wr(SIC_ADDR_CTRL_LOW, 8'hFE); rd(SIC_ADDR_CTRL_LOW); chk(v, 8'h7E);
    wr(SIC_ADDR_CTRL_HIGH, 8'hFF); rd(SIC_ADDR_CTRL_HIGH); chk(v, 8'h77);
    wr(8'h0C, 8'hFF); rd(8'h0C); chk(v, 8'h00);
    chk(8'(n_calls), 8'h00);
    $display("test registers done");
    // all six pending: one grant per return, highest priority first
    for (int i = 0; i < 6; i++) begin
      pulse(6'h10);
      wait_call();
      chk(irq_ack.vector, vec_of(i));
      chk({5'h00, irq_ack.source}, 8'(i));
      rd(SIC_ADDR_CTRL_LOW); chk({7'h00, v[0]}, 8'h00);
    end
    rd(SIC_ADDR_CTRL_LOW); chk(v, 8'h0E);
    rd(SIC_ADDR_CTRL_HIGH); chk(v, 8'h07);
    $display("test priority done");
    // full stack holds the grant, plain return keeps master
    @(posedge core_clk);
    hold_stack <= 1'b1;
    c0 = n_calls;
    wr(SIC_ADDR_CTRL_LOW, 8'h49); cyc(12); chk(8'(n_calls - c0), 8'h00);
    pulse(6'h20); rd(SIC_ADDR_CTRL_LOW); chk(v, 8'h49);
    @(posedge core_clk);
    hold_stack <= 1'b0;
    wait_call(); chk(irq_ack.vector, 8'h0C);
    rd(SIC_ADDR_CTRL_LOW); chk(v, 8'h08);
    // event and software clear on one edge
    @(posedge core_clk);
    mem_addr <= SIC_ADDR_CTRL_LOW;
    mem_wdata <= 8'h00;
    mem_wr <= 1'b1;
    ev <= 6'h01;
    @(posedge core_clk);
    mem_wr <= 1'b0;
    ev <= 6'h00;
    rd(SIC_ADDR_CTRL_LOW); chk(v, 8'h40);
    // software re-enable inside a service routine lets the kept flag through
    wr(SIC_ADDR_CTRL_LOW, 8'h49);
    wait_call();
    chk(irq_ack.vector, 8'h0C);
    $display("test stack done");
    // random events with master off: recorded, never served
    c0 = n_calls;
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr(SIC_ADDR_CTRL_LOW, {4'h0, rnd[2:0], 1'b0});
      wr(SIC_ADDR_CTRL_HIGH, {5'h00, rnd[5:3]});
      @(posedge core_clk);
      ev <= {2'b00, rnd[9:6]};
      pins <= ~rnd[11:10];
      @(posedge core_clk);
      ev <= 6'h00;
      cyc(2);
      pins <= 2'b11;
      cyc(5);
      rd(SIC_ADDR_CTRL_LOW); chk(v, {1'b0, rnd[6], rnd[11:10], rnd[2:0], 1'b0});
      rd(SIC_ADDR_CTRL_HIGH); chk(v, {1'b0, rnd[9:7], 1'b0, rnd[5:3]});
    end
    chk(8'(n_calls - c0), 8'h00);
    $display("test random done");
    finish_test();
  end
endmodule : six_source_interrupt_controller_bench
